// ==== rtl/dcmdio_pkg.sv ====
// dcmdio_pkg.sv: shared constants for the dual-format management link
//------------------------------------------------------------
// Overview of operation
// R1: two wires, clock plus shared data line
// R2: preamble of 32 or more ones
// R3: start 01 older, 00 extended format
// R4: format chosen per frame by second start bit
// R5: older format: 10 read, 01 write
// R6: extended: 00 addr, 01 wr, 11 rd, 10 rdinc
// R7: respond only when port address matches straps
// R8: older format register address selects register
// R9: extended device address must match strapped value
// R10: turnaround: read Z0 by device, write 10
// R11: sixteen data bits, writer drives them
// R12: address frame stores sixteen-bit register address
// R13: read-increment adds one to stored address
// R14: line released after data, idle reads one
// R15: two straps select device address 5,4,31,30
// R16: older format: 32 devices, 32 registers
// R17: straps latched on rising edge of reset
// R18: register decode independent of device address
// R19: sample on rising edge, msb first
// R20: mismatched or invalid frames ignored, line undriven
//------------------------------------------------------------
package dcmdio_pkg;
	localparam int          DCM_PRE_MIN   = 32;
	localparam int          DCM_PRE_CW    = 6;
	localparam logic [1:0]  DCM_ST_OLD    = 2'h1;
	localparam logic [1:0]  DCM_ST_EXT    = 2'h0;
	localparam logic [1:0]  DCM_OP_OLD_RD = 2'h2;
	localparam logic [1:0]  DCM_OP_OLD_WR = 2'h1;
	localparam logic [1:0]  DCM_OP_ADDR   = 2'h0;
	localparam logic [1:0]  DCM_OP_WR     = 2'h1;
	localparam logic [1:0]  DCM_OP_RD     = 2'h3;
	localparam logic [1:0]  DCM_OP_RDINC  = 2'h2;
	localparam logic [4:0]  DCM_DEV_11    = 5'h05;
	localparam logic [4:0]  DCM_DEV_10    = 5'h04;
	localparam logic [4:0]  DCM_DEV_01    = 5'h1f;
	localparam logic [4:0]  DCM_DEV_00    = 5'h1e;
	localparam int          DCM_HDR_BITS  = 14;
	localparam int          DCM_DATA_BITS = 16;
	localparam int          DCM_HOST_DIV  = 10;
	localparam logic [15:0] DCM_ADDR_RST  = 16'h0000;
	localparam int          DCM_FRAME_LEN = 64;
endpackage : dcmdio_pkg

// ==== rtl/dcmdio_if.sv ====
// dcmdio_if.sv: two-wire management link between station and device
`timescale 1ns/1ps
interface dcmdio_if;
	logic mdc;
	logic sta_mdio_o;
	logic sta_mdio_oe;
	logic dev_mdio_o;
	logic dev_mdio_oe;
	wire  mdio_line;
	// pull-up when nobody drives
	assign mdio_line = (sta_mdio_oe ? sta_mdio_o : 1'b1) & (dev_mdio_oe ? dev_mdio_o : 1'b1);
	modport sta (output mdc, output sta_mdio_o, output sta_mdio_oe, input dev_mdio_o, input dev_mdio_oe, input mdio_line);
	modport dev (input mdc, input sta_mdio_o, input sta_mdio_oe, output dev_mdio_o, output dev_mdio_oe, input mdio_line);
endinterface : dcmdio_if

// ==== rtl/dcmdio_dev.sv ====
// dcmdio_dev.sv: device end, frame decoder clocked by the management clock
`timescale 1ns/1ps
module dcmdio_dev
	import dcmdio_pkg::*;
(
	dcmdio_if.dev            LINK,             // management link
	input  wire logic        CLK_I,            // system clock
	input  wire logic        NRST_I,           // chip reset, active low
	input  wire logic [4:0]  PORT_ADDR_I,      // port address straps
	input  wire logic        DEVADDR_STRAP_LOW_I,  // strap pin level (low bit)
	input  wire logic        DEVADDR_STRAP_HIGH_I, // strap pin level (high bit)
	output logic             STRAP_OE_O,       // strap pins driven after reset
	input  wire logic [15:0] RD_DATA_I,        // register read data (system domain)
	output logic             WR_STB_O,         // write pulse, system domain
	output logic             RD_STB_O,         // read request pulse, system domain
	output logic             OLD_FMT_O,        // access used older format
	output logic [15:0]      REG_ADDR_O,       // register address of access
	output logic [15:0]      WR_DATA_O,        // write data
	output logic [4:0]       DEVADDR_O         // strapped device address
);
	typedef enum logic [4:0] {
		DCM_S_PRE  = 5'h01,
		DCM_S_HDR  = 5'h02,
		DCM_S_TA   = 5'h04,
		DCM_S_DATA = 5'h08,
		DCM_S_SKIP = 5'h10
	} dcm_state_t;

	//--------------------------------------------------------
	// strap capture on reset release
	//--------------------------------------------------------
	logic       rst_s1_q, rst_s2_q, rst_s1_d, rst_s2_d;
	logic       strap_lo_q, strap_hi_q, strap_lo_d, strap_hi_d;
	logic       strap_taken_q, strap_taken_d;
	logic [4:0] devaddr;

	always_comb begin
		rst_s1_d      = 1'b1;
		rst_s2_d      = rst_s1_q;
		strap_taken_d = strap_taken_q | rst_s2_q;
		strap_lo_d    = strap_lo_q;
		strap_hi_d    = strap_hi_q;
		if (!strap_taken_q) begin
			strap_lo_d = DEVADDR_STRAP_LOW_I; // [R17]
			strap_hi_d = DEVADDR_STRAP_HIGH_I; // [R17]
		end
		case ({strap_hi_q, strap_lo_q})
			2'h3:    devaddr = DCM_DEV_11; // [R15]
			2'h2:    devaddr = DCM_DEV_10; // [R15]
			2'h1:    devaddr = DCM_DEV_01; // [R15]
			default: devaddr = DCM_DEV_00; // [R15]
		endcase
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rst_s1_q      <= 1'b0;
			rst_s2_q      <= 1'b0;
			strap_taken_q <= 1'b0;
			strap_lo_q    <= 1'b1;
			strap_hi_q    <= 1'b1;
		end else begin
			rst_s1_q      <= rst_s1_d;
			rst_s2_q      <= rst_s2_d;
			strap_taken_q <= strap_taken_d;
			strap_lo_q    <= strap_lo_d;
			strap_hi_q    <= strap_hi_d;
		end
	end

	//--------------------------------------------------------
	// link domain: frame decoder on mdc
	//--------------------------------------------------------
	dcm_state_t  st_q, st_d;
	logic [5:0]  cnt_q, cnt_d;
	logic [13:0] hdr_q, hdr_d;
	logic [15:0] sh_q, sh_d;
	logic [15:0] ext_addr_q, ext_addr_d;
	logic        oe_q, oe_d, do_q, do_d;
	logic        go_q, go_d;
	logic        rd_tgl_q, rd_tgl_d, wr_tgl_q, wr_tgl_d;
	logic [15:0] l_addr_q, l_addr_d, l_wdat_q, l_wdat_d;
	logic        l_old_q, l_old_d;
	logic [4:0]  dev_l_s1_q, dev_l_s2_q;
	logic [4:0]  pa_s1_q, pa_s2_q;
	logic [15:0] rdat_s1_q, rdat_s2_q;
	logic        lrst_s1_q, lrst_n;
	logic        bit_in;
	logic        old_f, match, is_rd, is_wr, valid;
	logic [1:0]  op_f;

	assign bit_in = LINK.mdio_line; // [R19]
	assign old_f  = hdr_q[12]; // [R4]
	assign op_f   = hdr_q[11:10];

	always_ff @(posedge LINK.mdc or negedge NRST_I) begin
		if (!NRST_I) begin
			lrst_s1_q <= 1'b0;
			lrst_n    <= 1'b0;
		end else begin
			lrst_s1_q <= 1'b1;
			lrst_n    <= lrst_s1_q;
		end
	end

	always_ff @(posedge LINK.mdc or negedge lrst_n) begin
		if (!lrst_n) begin
			dev_l_s1_q <= 5'h00;
			dev_l_s2_q <= 5'h00;
			pa_s1_q    <= 5'h00;
			pa_s2_q    <= 5'h00;
			rdat_s1_q  <= 16'h0000;
			rdat_s2_q  <= 16'h0000;
		end else begin
			dev_l_s1_q <= devaddr;
			dev_l_s2_q <= dev_l_s1_q;
			pa_s1_q    <= PORT_ADDR_I;
			pa_s2_q    <= pa_s1_q;
			rdat_s1_q  <= RD_DATA_I;
			rdat_s2_q  <= rdat_s1_q;
		end
	end

	always_comb begin
		match = (hdr_q[9:5] == pa_s2_q) // [R7]
			&& (old_f || hdr_q[4:0] == dev_l_s2_q); // [R9]
		is_rd = old_f ? (op_f == DCM_OP_OLD_RD) : (op_f == DCM_OP_RD || op_f == DCM_OP_RDINC); // [R5] [R6]
		is_wr = old_f ? (op_f == DCM_OP_OLD_WR) : (op_f == DCM_OP_WR || op_f == DCM_OP_ADDR); // [R5] [R6]
		valid = match && (is_rd || is_wr); // [R20]
		st_d = st_q; cnt_d = cnt_q; hdr_d = hdr_q; sh_d = sh_q;
		ext_addr_d = ext_addr_q; oe_d = 1'b0; do_d = 1'b1; go_d = go_q;
		rd_tgl_d = rd_tgl_q; wr_tgl_d = wr_tgl_q;
		l_addr_d = l_addr_q; l_wdat_d = l_wdat_q; l_old_d = l_old_q;
		case (st_q)
			DCM_S_PRE: begin
				if (bit_in) begin
					if (cnt_q < 6'(DCM_PRE_MIN)) cnt_d = cnt_q + 6'h01; // [R2]
				end else if (cnt_q >= 6'(DCM_PRE_MIN)) begin // [R2] [R14]
					st_d = DCM_S_HDR;
					cnt_d = 6'h00;
					hdr_d = 14'h0000;
				end else begin
					cnt_d = 6'h00;
				end
			end
			DCM_S_HDR: begin
				hdr_d = {hdr_q[12:0], bit_in}; // [R19]
				cnt_d = cnt_q + 6'h01;
				if (cnt_q == 6'(DCM_HDR_BITS - 2)) begin
					// last register or device address bit arrives now
					st_d = DCM_S_TA;
					cnt_d = 6'h00;
				end
			end
			DCM_S_TA: begin
				cnt_d = cnt_q + 6'h01;
				if (cnt_q == 6'h00) begin
					// only hdr[13] is checked: never shifted in, it stays zero
					go_d = valid && hdr_q[13] == 1'b0; // [R3]
					l_old_d = old_f;
					l_addr_d = old_f ? {11'h000, hdr_q[4:0]} : ext_addr_q; // [R8] [R16] [R18]
					if (valid && is_rd && hdr_q[13] == 1'b0) begin
						oe_d = 1'b1; // [R10]
						do_d = 1'b0; // [R10]
						rd_tgl_d = ~rd_tgl_q;
					end
				end else begin
					st_d = go_q ? DCM_S_DATA : DCM_S_SKIP; // [R20]
					cnt_d = 6'h00;
					if (go_q && is_rd) begin
						oe_d = 1'b1; // [R11]
						do_d = rdat_s2_q[15]; // [R19]
						sh_d = {rdat_s2_q[14:0], 1'b0};
					end
				end
			end
			DCM_S_DATA: begin
				cnt_d = cnt_q + 6'h01;
				if (is_rd && cnt_q < 6'(DCM_DATA_BITS - 1)) begin
					oe_d = 1'b1; // [R11]
					do_d = sh_q[15];
					sh_d = {sh_q[14:0], 1'b0};
				end
				if (is_wr) sh_d = {sh_q[14:0], bit_in}; // [R11]
				if (cnt_q == 6'(DCM_DATA_BITS - 1)) begin
					st_d = DCM_S_PRE; // [R14]
					cnt_d = 6'h00;
					if (is_wr && !old_f && op_f == DCM_OP_ADDR) begin
						ext_addr_d = {sh_q[14:0], bit_in}; // [R12]
					end else if (is_wr) begin
						l_wdat_d = {sh_q[14:0], bit_in};
						wr_tgl_d = ~wr_tgl_q;
					end
					if (!old_f && op_f == DCM_OP_RDINC) ext_addr_d = ext_addr_q + 16'h0001; // [R13]
				end
			end
			DCM_S_SKIP: begin
				cnt_d = cnt_q + 6'h01;
				if (cnt_q == 6'(DCM_DATA_BITS - 1)) begin
					st_d = DCM_S_PRE;
					cnt_d = 6'h00;
				end
			end
			default: st_d = DCM_S_PRE;
		endcase
	end

	always_ff @(posedge LINK.mdc or negedge lrst_n) begin
		if (!lrst_n) begin
			st_q <= DCM_S_PRE; cnt_q <= 6'h00; hdr_q <= 14'h0000; sh_q <= 16'h0000;
			ext_addr_q <= DCM_ADDR_RST; oe_q <= 1'b0; do_q <= 1'b1; go_q <= 1'b0;
			rd_tgl_q <= 1'b0; wr_tgl_q <= 1'b0;
			l_addr_q <= 16'h0000; l_wdat_q <= 16'h0000; l_old_q <= 1'b0;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; hdr_q <= hdr_d; sh_q <= sh_d;
			ext_addr_q <= ext_addr_d; oe_q <= oe_d; do_q <= do_d; go_q <= go_d;
			rd_tgl_q <= rd_tgl_d; wr_tgl_q <= wr_tgl_d;
			l_addr_q <= l_addr_d; l_wdat_q <= l_wdat_d; l_old_q <= l_old_d;
		end
	end

	assign LINK.dev_mdio_oe = oe_q; // [R1] [R20]
	assign LINK.dev_mdio_o  = do_q;

	//--------------------------------------------------------
	// system domain: toggle crossings to strobes
	//--------------------------------------------------------
	logic [2:0] rt_q, rt_d, wt_q, wt_d;
	logic       wr_stb_d, rd_stb_d, old_d;
	logic [15:0] addr_d, wdat_d;

	always_comb begin
		rt_d = {rt_q[1:0], rd_tgl_q};
		wt_d = {wt_q[1:0], wr_tgl_q};
		rd_stb_d = rt_q[2] ^ rt_q[1];
		wr_stb_d = wt_q[2] ^ wt_q[1];
		addr_d = REG_ADDR_O; wdat_d = WR_DATA_O; old_d = OLD_FMT_O;
		if ((rt_q[2] ^ rt_q[1]) || (wt_q[2] ^ wt_q[1])) begin
			// link-side words are stable for many mdc periods here
			addr_d = l_addr_q;
			wdat_d = l_wdat_q;
			old_d  = l_old_q;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rt_q <= 3'h0; wt_q <= 3'h0; RD_STB_O <= 1'b0; WR_STB_O <= 1'b0;
			REG_ADDR_O <= 16'h0000; WR_DATA_O <= 16'h0000; OLD_FMT_O <= 1'b0;
			DEVADDR_O <= DCM_DEV_11; STRAP_OE_O <= 1'b0;
		end else begin
			rt_q <= rt_d; wt_q <= wt_d; RD_STB_O <= rd_stb_d; WR_STB_O <= wr_stb_d;
			REG_ADDR_O <= addr_d; WR_DATA_O <= wdat_d; OLD_FMT_O <= old_d;
			DEVADDR_O <= devaddr; STRAP_OE_O <= strap_taken_q; // [R17]
		end
	end
endmodule : dcmdio_dev

// ==== rtl/dcmdio_sta.sv ====
// dcmdio_sta.sv: station end, builds frames and drives the management clock
`timescale 1ns/1ps
module dcmdio_sta
	import dcmdio_pkg::*;
(
	dcmdio_if.sta            LINK,       // management link
	input  wire logic        CLK_I,      // system clock
	input  wire logic        NRST_I,     // reset, active low
	input  wire logic        REQ_I,      // start a frame, level held until ACK
	input  wire logic        OLD_FMT_I,  // 1 older format, 0 extended
	input  wire logic [1:0]  OP_I,       // opcode
	input  wire logic [4:0]  PORT_I,     // port address
	input  wire logic [4:0]  DEV_I,      // register or device address
	input  wire logic [15:0] DATA_I,     // write data or address
	output logic             ACK_O,      // frame done pulse
	output logic             BUSY_O,     // frame in progress
	output logic [15:0]      RD_DATA_O   // read data
);
	typedef enum logic [1:0] {DCM_H_IDLE = 2'h1, DCM_H_RUN = 2'h2} dcm_hst_t;

	dcm_hst_t    st_q, st_d;
	logic [3:0]  div_q, div_d;
	logic        mdc_q, mdc_d;
	logic [6:0]  bit_q, bit_d;
	logic [63:0] fr_q, fr_d;
	logic        rd_q, rd_d, oe_q, oe_d, do_q, do_d, ack_d, busy_d;
	logic [15:0] rdat_d;
	logic        in_s1_q, in_s2_q;
	logic        rise;

	assign rise = (div_q == 4'(DCM_HOST_DIV / 2 - 1)) && !mdc_q;

	always_comb begin
		st_d = st_q; div_d = div_q + 4'h1; mdc_d = mdc_q; bit_d = bit_q; fr_d = fr_q;
		rd_d = rd_q; oe_d = oe_q; do_d = do_q; ack_d = 1'b0; busy_d = BUSY_O; rdat_d = RD_DATA_O;
		if (div_q == 4'(DCM_HOST_DIV / 2 - 1)) begin
			div_d = 4'h0;
			mdc_d = ~mdc_q; // [R1]
		end
		case (st_q)
			DCM_H_IDLE: begin
				// start just before a falling edge, so no rising edge precedes bit 0
				if (REQ_I && !BUSY_O && !ACK_O && div_q == 4'(DCM_HOST_DIV / 2 - 1) && mdc_q) begin
					st_d = DCM_H_RUN; busy_d = 1'b1; bit_d = 7'h00;
					rd_d = OLD_FMT_I ? (OP_I == DCM_OP_OLD_RD) : OP_I[1];
					fr_d = {32'hffffffff, (OLD_FMT_I ? DCM_ST_OLD : DCM_ST_EXT), OP_I, PORT_I, DEV_I, // [R2] [R3]
						(OLD_FMT_I ? (OP_I == DCM_OP_OLD_RD) : OP_I[1]) ? 2'h3 : 2'h2, DATA_I}; // [R10]
				end
			end
			DCM_H_RUN: begin
				if (div_q == 4'h0 && !mdc_q) begin
					// change data on falling edge, msb first
					oe_d = !(rd_q && bit_q >= 7'd46) && bit_q < 7'(DCM_FRAME_LEN); // [R10] [R14] [R19]
					do_d = fr_q[63];
					fr_d = {fr_q[62:0], 1'b0};
					if (bit_q == 7'(DCM_FRAME_LEN)) begin
						st_d = DCM_H_IDLE; busy_d = 1'b0; ack_d = 1'b1; oe_d = 1'b0;
					end
				end
				if (rise) begin
					if (bit_q < 7'(DCM_FRAME_LEN)) bit_d = bit_q + 7'h01;
					if (rd_q && bit_q >= 7'd48) rdat_d = {RD_DATA_O[14:0], in_s2_q}; // [R11] [R19]
				end
			end
			default: st_d = DCM_H_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_q <= DCM_H_IDLE; div_q <= 4'h0; mdc_q <= 1'b0; bit_q <= 7'h00; fr_q <= 64'h0;
			rd_q <= 1'b0; oe_q <= 1'b0; do_q <= 1'b1; ACK_O <= 1'b0; BUSY_O <= 1'b0;
			RD_DATA_O <= 16'h0000; in_s1_q <= 1'b1; in_s2_q <= 1'b1;
		end else begin
			st_q <= st_d; div_q <= div_d; mdc_q <= mdc_d; bit_q <= bit_d; fr_q <= fr_d;
			rd_q <= rd_d; oe_q <= oe_d; do_q <= do_d; ACK_O <= ack_d; BUSY_O <= busy_d;
			RD_DATA_O <= rdat_d; in_s1_q <= LINK.mdio_line; in_s2_q <= in_s1_q;
		end
	end

	assign LINK.mdc        = mdc_q;
	assign LINK.sta_mdio_o  = do_q;
	assign LINK.sta_mdio_oe = oe_q;
endmodule : dcmdio_sta

// ==== dv/dcmdio_sva.sv ====
// dcmdio_sva.sv: wire-level checks on the management link
`timescale 1ns/1ps
module dcmdio_sva (
	input wire logic mdc,         // link clock
	input wire logic NRST_I,      // reset, active low
	input wire logic sta_mdio_o,  // station data out
	input wire logic sta_mdio_oe, // station drives line
	input wire logic dev_mdio_o,  // device data out
	input wire logic dev_mdio_oe, // device drives line
	input wire logic mdio_line    // resolved line
);
	//------------------------------
	// frame position tracker
	//------------------------------
	logic [5:0] ones_q;
	logic [5:0] ones_d;
	logic [5:0] pos_q;
	logic [5:0] pos_d;
	always_comb begin
		ones_d = 6'h00;
		if (pos_q == 6'h00 && mdio_line)
			ones_d = (ones_q == 6'h3f) ? ones_q : ones_q + 6'h01;
		// pos is the index of the bit sampled at this edge, wraps after 63
		pos_d = (pos_q == 6'h00) ? 6'h00 : pos_q + 6'h01;
		if (pos_q == 6'h00 && !mdio_line && ones_q >= 6'h20)
			pos_d = 6'h21;
	end
	always_ff @(posedge mdc or negedge NRST_I) begin
		if (!NRST_I) begin
			ones_q <= 6'h00;
			pos_q  <= 6'h00;
		end else begin
			ones_q <= ones_d;
			pos_q  <= pos_d;
		end
	end
	//------------------------------
	// assertions
	//------------------------------
	default clocking cb @(posedge mdc); endclocking
	default disable iff (!NRST_I);
	no_contention_a: assert property (!(sta_mdio_oe && dev_mdio_oe))
		else $error("both ends drive the line");
	dev_ta_zero_a: assert property ($rose(dev_mdio_oe) |-> pos_q == 6'h2f && !dev_mdio_o)
		else $error("device turnaround bit wrong");
	dev_length_a: assert property ($rose(dev_mdio_oe) |=> dev_mdio_oe[*8] ##1 dev_mdio_oe[*8] ##1 !dev_mdio_oe)
		else $error("device data field not sixteen bits");
	dev_window_a: assert property (dev_mdio_oe |-> pos_q >= 6'h2f)
		else $error("device drives outside read data");
	pre_count_a: assert property ((pos_q == 6'h00 && !mdio_line) |-> ones_q >= 6'h20)
		else $error("start without full preamble");
	sta_pre_a: assert property ($rose(sta_mdio_oe) |-> sta_mdio_o[*8])
		else $error("station frame opens without ones");
	wr_ta_a: assert property ((pos_q == 6'h2e && sta_mdio_oe) |-> sta_mdio_o ##1 (sta_mdio_oe && !sta_mdio_o))
		else $error("write turnaround not one then zero");
	sta_release_a: assert property ((pos_q == 6'h2e && !sta_mdio_oe) |-> !sta_mdio_oe[*8] ##1 !sta_mdio_oe[*8])
		else $error("station drives during read data");
	line_idle_a: assert property (pos_q == 6'h3f |=> !dev_mdio_oe && mdio_line)
		else $error("line not released after data");
endmodule : dcmdio_sva

// ==== dv/tb_top.sv ====
// tb_top.sv: end-to-end bench for the dual-format management link
`timescale 1ns/1ps
module tb_top;
	import dcmdio_pkg::*;
	logic        clk, rst_n, req, old_fmt, ack, busy, s_lo, s_hi, strap_oe, wr_stb, rd_stb, old_o, last_old;
	logic [1:0]  op;
	logic [4:0]  port, dev, devaddr;
	logic [15:0] data, rd_data, reg_rd, reg_addr, wr_data, got, last_addr, last_data;
	int          n_wr, n_rd, n0, mismatches, total_checks, cycles;
	logic [4:0]  dev_tab [4] = '{5'h1e, 5'h1f, 5'h04, 5'h05};
	logic [1:0]  rop_tab [4] = '{2'h2, 2'h2, 2'h3, 2'h3};
	logic [15:0] rad_tab [4] = '{16'h00fe, 16'h00ff, 16'h0100, 16'h0100};
	dcmdio_if link_if();
	dcmdio_sta dcmdio_sta_inst (.LINK(link_if.sta), .CLK_I(clk), .NRST_I(rst_n), .REQ_I(req), .OLD_FMT_I(old_fmt),
		.OP_I(op), .PORT_I(port), .DEV_I(dev), .DATA_I(data), .ACK_O(ack), .BUSY_O(busy), .RD_DATA_O(rd_data));
	dcmdio_dev dcmdio_dev_inst (.LINK(link_if.dev), .CLK_I(clk), .NRST_I(rst_n), .PORT_ADDR_I(5'h0b),
		.DEVADDR_STRAP_LOW_I(s_lo), .DEVADDR_STRAP_HIGH_I(s_hi), .STRAP_OE_O(strap_oe), .RD_DATA_I(reg_rd),
		.WR_STB_O(wr_stb), .RD_STB_O(rd_stb), .OLD_FMT_O(old_o), .REG_ADDR_O(reg_addr), .WR_DATA_O(wr_data),
		.DEVADDR_O(devaddr));
	dcmdio_sva dcmdio_sva_inst (.mdc(link_if.mdc), .NRST_I(rst_n), .sta_mdio_o(link_if.sta_mdio_o),
		.sta_mdio_oe(link_if.sta_mdio_oe), .dev_mdio_o(link_if.dev_mdio_o), .dev_mdio_oe(link_if.dev_mdio_oe),
		.mdio_line(link_if.mdio_line));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	//------------------------------
	// strobe monitor and watchdog
	//------------------------------
	always @(posedge clk) begin
		cycles++;
		if (wr_stb === 1'b1) begin
			n_wr++;
			last_addr = reg_addr;
			last_data = wr_data;
			last_old = old_o;
		end
		if (rd_stb === 1'b1) begin
			n_rd++;
			last_addr = reg_addr;
			last_old = old_o;
		end
		if (cycles == 30000) begin
			mismatches++;
			summarize();
		end
	end
	//------------------------------
	// tasks
	//------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic do_reset(input logic hi, input logic lo);
		@(negedge clk);
		rst_n = 1'b0;
		s_hi = hi;
		s_lo = lo;
		repeat (20) @(negedge clk);
		chk({15'h0000, strap_oe}, 16'h0000);
		rst_n = 1'b1;
		repeat (40) @(negedge clk);
		chk({15'h0000, strap_oe}, 16'h0001);
	endtask : do_reset
	// one whole frame; request held until the done pulse is seen
	task automatic frame(input logic f_old, input logic [1:0] f_op, input logic [4:0] f_port,
		input logic [4:0] f_dev, input logic [15:0] f_data);
		int n;
		@(negedge clk);
		old_fmt = f_old;
		op = f_op;
		port = f_port;
		dev = f_dev;
		data = f_data;
		req = 1'b1;
		repeat (12) @(negedge clk);
		chk({15'h0000, busy}, 16'h0001);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (ack !== 1'b1 && n < 2000);
		got = rd_data;
		chk({15'h0000, ack}, 16'h0001);
		@(negedge clk);
		req = 1'b0;
		chk({15'h0000, busy}, 16'h0000);
		repeat (40) @(negedge clk);
	endtask : frame
	//------------------------------
	// main sequence
	//------------------------------
	initial begin
		rst_n = 1'b0;
		req = 1'b0;
		old_fmt = 1'b0;
		op = 2'h0;
		port = 5'h00;
		dev = 5'h00;
		data = 16'h0000;
		s_lo = 1'b1;
		s_hi = 1'b1;
		reg_rd = 16'hb3c5;
		for (int k = 0; k < 4; k++) begin
			do_reset(k[1], k[0]);
			chk({11'h000, devaddr}, {11'h000, dev_tab[k]});
			s_hi = ~s_hi;
			s_lo = ~s_lo;
			frame(1'b0, 2'h0, 5'h0b, dev_tab[k], 16'h0c00 + 16'(k));
			frame(1'b0, 2'h1, 5'h0b, dev_tab[k], 16'h5a00 + 16'(k));
			chk(last_addr, 16'h0c00 + 16'(k));
			chk(last_data, 16'h5a00 + 16'(k));
			chk({11'h000, devaddr}, {11'h000, dev_tab[k]});
		end
		for (int k = 0; k < 2; k++) begin
			frame(1'b1, 2'h1, 5'h0b, 5'(k * 31), 16'hc3a5 ^ 16'(k));
			chk(last_addr, 16'(k * 31));
			chk(last_data, 16'hc3a5 ^ 16'(k));
			chk({15'h0000, last_old}, 16'h0001);
		end
		frame(1'b1, 2'h2, 5'h0b, 5'h11, 16'h0000);
		chk(got, 16'hb3c5);
		chk(last_addr, 16'h0011);
		frame(1'b0, 2'h0, 5'h0b, 5'h05, 16'h00fe);
		n0 = n_wr + n_rd;
		frame(1'b1, 2'h0, 5'h0b, 5'h01, 16'hffff);
		frame(1'b1, 2'h3, 5'h0b, 5'h01, 16'hffff);
		frame(1'b1, 2'h1, 5'h0a, 5'h01, 16'h1234);
		frame(1'b1, 2'h1, 5'h1b, 5'h01, 16'h1234);
		frame(1'b0, 2'h0, 5'h0b, 5'h04, 16'h7777);
		frame(1'b0, 2'h0, 5'h0a, 5'h05, 16'h7777);
		chk(16'(n_wr + n_rd - n0), 16'h0000);
		reg_rd = 16'h7e81;
		for (int k = 0; k < 4; k++) begin
			frame(1'b0, rop_tab[k], 5'h0b, 5'h05, 16'h0000);
			chk(last_addr, rad_tab[k]);
			chk(got, 16'h7e81);
		end
		frame(1'b1, 2'h1, 5'h0b, 5'h03, 16'h0f0f);
		frame(1'b0, 2'h1, 5'h0b, 5'h05, 16'h9669);
		chk(last_addr, 16'h0100);
		chk({15'h0000, last_old}, 16'h0000);
		chk(last_data, 16'h9669);
		summarize();
	end
endmodule : tb_top
